// File: dv/isd_ctl_model.sv
// Disk controller model: watches the index and sector lines and times their pulses
`timescale 1ns/1ps
`default_nettype none
module isd_ctl_model (
	input  wire logic ref_clk,
	input  wire logic index_in,
	input  wire logic sector_in,
	output logic      idx_rise,
	output logic      idx_fall,
	output logic      sec_rise,
	output logic      sec_fall,
	output var int    idx_len,
	output var int    sec_len
);
	logic idx_seen_reg = 1'b0;
	logic sec_seen_reg = 1'b0;

	// Edges against the previous sample; a controller only sees levels
	assign idx_rise = index_in & ~idx_seen_reg;
	assign idx_fall = ~index_in & idx_seen_reg;
	assign sec_rise = sector_in & ~sec_seen_reg;
	assign sec_fall = ~sector_in & sec_seen_reg;

	// Length of each high run, still held in the cycle of the fall
	always @(posedge ref_clk) begin
		idx_seen_reg <= index_in;
		sec_seen_reg <= sector_in;
		idx_len <= index_in ? idx_len + 1 : 0;
		sec_len <= sector_in ? sec_len + 1 : 0;
	end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the index and sector detector
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import isd_pkg::*;
	logic             ref_clk = 1'b0;
	logic             rst_n = 1'b0;
	logic             dibit_in = 1'b0;
	logic             clk806_in = 1'b0;
	logic [CNT_W-1:0] sector_preset = PRESET_DEF;
	logic             index_out;
	logic             sector_out;
	logic [SEC_W-1:0] present_sector;
	logic             idx_rise, idx_fall, sec_rise, sec_fall;
	int               idx_len, sec_len;
	int               error_cnt = 0;
	int               n_checks = 0;
	int               k = 0, exp_sec = 0, len = 4, n_idx = 0;
	bit               armed = 0, gap_on = 0, last_drop = 0;

	// 50 ns system clock
	always #25 ref_clk = ~ref_clk;

	// Pattern 8'hf0: four ones then four missing-dibit samples, newest in bit 0
	isd_top #(.INDEX_PATTERN(8'hf0)) i_isd_top (
		.ref_clk(ref_clk), .rst_n(rst_n), .dibit_in(dibit_in), .clk806_in(clk806_in),
		.sector_preset(sector_preset), .index_out(index_out), .sector_out(sector_out),
		.present_sector(present_sector));

	isd_ctl_model i_isd_ctl_model (
		.ref_clk(ref_clk), .index_in(index_out), .sector_in(sector_out), .idx_rise(idx_rise),
		.idx_fall(idx_fall), .sec_rise(sec_rise), .sec_fall(sec_fall), .idx_len(idx_len),
		.sec_len(sec_len));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One dibit period of 24 cycles; a dropped dibit leaves the line low
	task automatic tick(input bit drop);
		@(posedge ref_clk);
		clk806_in <= 1'b1;
		dibit_in <= ~drop;
		k++;
		repeat (2) @(posedge ref_clk);
		dibit_in <= 1'b0;
		repeat (10) @(posedge ref_clk);
		clk806_in <= 1'b0;
		repeat (11) @(posedge ref_clk);
	endtask

	// Normal track: isolated random dropouts must never look like the index
	task automatic run(input int n);
		bit d;
		repeat (n) begin
			d = ($urandom % 4 == 0) && !last_drop;
			last_drop = d;
			tick(d);
		end
	endtask

	// Reference model: sector n rises len-1+n*len ticks after the index falls
	always @(posedge ref_clk) if (rst_n) begin
		if (idx_rise) begin
			n_idx++;
			armed = 0;
			chk(32'(gap_on), 32'h1);
		end
		if (idx_fall) begin
			chk(32'(idx_len), IDX_PULSE_CYC);
			chk({25'h0, present_sector}, 32'h0);
			k = 0;
			exp_sec = 0;
			armed = 1;
			gap_on = 0;
		end
		if (armed && sec_rise) begin
			chk(32'(k), 32'(len - 1 + exp_sec * len));
			exp_sec++;
			chk({25'h0, present_sector}, 32'(exp_sec % 128));
		end
		if (armed && sec_fall) begin
			chk(32'(sec_len), 32'h18);
		end
	end

	// Two revolutions' worth of sectors, each with its own random length
	initial begin
		void'($urandom(32'h97b1));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			armed = 0;
			len = 2 + $urandom % 4;
			sector_preset <= 12'(4096 - len);
			run(20);
			// Every other dibit missing, in both phases of the 403 kHz tick: no index
			for (int s = 0; s < 2; s++) begin
				repeat (6) begin
					tick(1'b0);
					tick(1'b1);
				end
				tick(1'b0);
			end
			repeat (8) tick(1'b0);
			gap_on = 1;
			repeat (12) tick(1'b1);
			run(135 * len);
			chk(32'(n_idx), 32'(p + 1));
			$display("test %0d done, sector length %0d", p, len);
		end
		summarize();
	end

	// Hang guard, well beyond the two passes of at most about 36000 cycles
	initial begin
		repeat (50000) @(posedge ref_clk);
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire

// File: logic/isd_pkg.sv
// Constants shared by the index and sector detector
`default_nettype none
package isd_pkg;
	// System clock rate
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned CLK_PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);
	// Index pulse width, a least time, so rounded up
	localparam int unsigned IDX_PULSE_NS  = 2500;
	localparam int unsigned IDX_PULSE_CYC =
		(IDX_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Missing dibit timeout: one lost dibit leaves two periods (2.48 us) between
	// dibits, two lost dibits leave three (3.72 us); the timeout sits between them
	localparam int unsigned MISS_TMO_NS   = 3100;
	localparam int unsigned MISS_TMO_CYC  = (MISS_TMO_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned TMR_W         = 6;
	localparam int unsigned IDX_W         = 6;
	localparam logic [TMR_W-1:0] MISS_TMO_LOAD = TMR_W'(MISS_TMO_CYC);
	localparam logic [IDX_W-1:0] IDX_PULSE_LOAD = IDX_W'(IDX_PULSE_CYC);
	// Sector bit counter layout
	localparam int unsigned CNT_W         = 12;
	localparam logic [CNT_W-1:0] CNT_MAX  = 12'hfff;
	localparam int unsigned REV_CLOCKS    = 13440;
	// Default preset: 4096 - 210 clocks, giving 64 sectors
	localparam logic [CNT_W-1:0] PRESET_DEF = 12'hf2e;
	// Present sector count and index shift register
	localparam int unsigned SEC_W         = 7;
	localparam int unsigned IDX_SR_W      = 8;
	localparam logic [IDX_SR_W-1:0] IDX_PATTERN_DEF = 8'hc3;
	// Index pulse state machine
	typedef enum logic [1:0] {
		ISD_IDX_WAIT  = 2'b00,
		ISD_IDX_PULSE = 2'b01,
		ISD_IDX_HOLD  = 2'b10
	} isd_idx_state_t;
endpackage
`default_nettype wire

// File: logic/isd_top.sv
// Index and sector detector: index from missing dibits, sector pulses, present sector
//
// Summary of operation
// R1: Index pattern recognised gives one index pulse 2.5 us wide.
// R2: Missing dibit timer restarts on each dibit; expires after two absent dibits.
// R3: Each 403 kHz tick shifts the index register, loading timer activity.
// R4: Decoder compares shift register with index pattern continuously; match asserts index.
// R5: Index goes out and resets the sector counters and present sector count.
// R6: Sector pulse stands while the sector bit counter equals 4095.
// R7: Sector bit counter advances once per 806 kHz tick, 13440 per revolution.
// R8: Tick after maximum reloads 4096 minus sector length, ending the pulse.
// R9: Sector length comes from a static preset on the load inputs.
// R10: Each sector pulse goes out and increments the present sector count.
// R11: Present sector count counts sectors from index, naming the sector underneath.
// R12: No counter advance while index is active; sector zero gets one more clock.
// R13: The 403 kHz reference is the 806 kHz clock halved.
// R14: Present sector count is seven bits wide.
// R15: Index width and missing dibit timeout are system clock cycle counts.
`timescale 1ns/1ps
`default_nettype none
module isd_top
	import isd_pkg::*;
#(
	parameter logic [IDX_SR_W-1:0] INDEX_PATTERN = IDX_PATTERN_DEF
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             dibit_in,
	input  wire logic             clk806_in,
	input  wire logic [CNT_W-1:0] sector_preset,
	output logic                  index_out,
	output logic                  sector_out,
	output logic [SEC_W-1:0]      present_sector
);

	////////////////////////////////////////////////////////////////////////
	// Input edges and the 403 kHz reference

	logic dibit_prev_reg;
	logic dibit_prev_next;
	logic ck_prev_reg;
	logic ck_prev_next;
	logic half_reg;
	logic half_next;
	logic dibit_rise;
	logic tick806;
	logic tick403;

	// Edge of each recovered dibit and of the dibit-locked clock
	always_comb begin
		dibit_prev_next = dibit_in;
		ck_prev_next    = clk806_in;
		dibit_rise      = dibit_in & ~dibit_prev_reg;
		tick806         = clk806_in & ~ck_prev_reg;
		// Halving the 806 kHz clock keeps the 403 kHz tick locked to dibits
		half_next       = tick806 ? ~half_reg : half_reg; // R13
		tick403         = tick806 & ~half_reg; // R13
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dibit_prev_reg <= 1'b0;
			ck_prev_reg    <= 1'b0;
			half_reg       <= 1'b0;
		end else begin
			dibit_prev_reg <= dibit_prev_next;
			ck_prev_reg    <= ck_prev_next;
			half_reg       <= half_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Missing dibit timer and index shift register

	logic [TMR_W-1:0]    tmr_reg;
	logic [TMR_W-1:0]    tmr_next;
	logic [IDX_SR_W-1:0] shift_reg;
	logic [IDX_SR_W-1:0] shift_next;
	logic                tmr_active;

	// Retriggerable timer: any dibit reloads it, so it only lapses on a gap
	always_comb begin
		tmr_active = (tmr_reg != '0); // R2
		tmr_next   = tmr_reg;
		if (dibit_rise) begin
			tmr_next = MISS_TMO_LOAD; // R2 R15
		end else if (tmr_active) begin
			tmr_next = tmr_reg - TMR_W'(1); // R2
		end
		shift_next = shift_reg;
		if (tick403) begin
			shift_next = {shift_reg[IDX_SR_W-2:0], tmr_active}; // R3
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tmr_reg   <= '0;
			shift_reg <= '0;
		end else begin
			tmr_reg   <= tmr_next;
			shift_reg <= shift_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Index decoder and pulse shaper

	isd_idx_state_t   idx_state_reg;
	isd_idx_state_t   idx_state_next;
	logic [IDX_W-1:0] idx_cnt_reg;
	logic [IDX_W-1:0] idx_cnt_next;
	logic             index_reg;
	logic             index_next;
	logic             idx_match;

	// The pattern stays in the register for a whole 403 kHz period, so the
	// HOLD state keeps one pattern from firing a second pulse.
	always_comb begin
		idx_match      = (shift_reg == INDEX_PATTERN); // R4
		idx_state_next = idx_state_reg;
		idx_cnt_next   = idx_cnt_reg;
		case (idx_state_reg)
			ISD_IDX_WAIT: begin
				if (idx_match) begin
					idx_state_next = ISD_IDX_PULSE; // R4
					idx_cnt_next   = IDX_PULSE_LOAD - IDX_W'(1); // R1 R15
				end
			end
			ISD_IDX_PULSE: begin
				if (idx_cnt_reg != '0) begin
					idx_cnt_next = idx_cnt_reg - IDX_W'(1); // R1
				end else if (idx_match) begin
					idx_state_next = ISD_IDX_HOLD;
				end else begin
					idx_state_next = ISD_IDX_WAIT;
				end
			end
			ISD_IDX_HOLD: begin
				if (!idx_match) begin
					idx_state_next = ISD_IDX_WAIT;
				end
			end
			default: begin
				idx_state_next = ISD_IDX_WAIT;
			end
		endcase
		index_next = (idx_state_next == ISD_IDX_PULSE); // R1
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idx_state_reg <= ISD_IDX_WAIT;
			idx_cnt_reg   <= '0;
			index_reg     <= 1'b0;
		end else begin
			idx_state_reg <= idx_state_next;
			idx_cnt_reg   <= idx_cnt_next;
			index_reg     <= index_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sector bit counter and present sector count

	logic [CNT_W-1:0] bit_cnt_reg;
	logic [CNT_W-1:0] bit_cnt_next;
	logic [SEC_W-1:0] sec_cnt_reg;
	logic [SEC_W-1:0] sec_cnt_next;
	logic             sector_reg;
	logic             sector_next;

	// Index holds the counter at its preset, so the first tick after index
	// is lost and sector zero runs one clock long.
	always_comb begin
		bit_cnt_next = bit_cnt_reg;
		sec_cnt_next = sec_cnt_reg;
		if (index_reg) begin
			bit_cnt_next = sector_preset; // R5 R9 R12
			sec_cnt_next = '0; // R5 R11
		end else if (tick806) begin
			if (bit_cnt_reg == CNT_MAX) begin
				bit_cnt_next = sector_preset; // R8 R9
			end else begin
				bit_cnt_next = bit_cnt_reg + CNT_W'(1); // R7
			end
		end
		sector_next = (bit_cnt_next == CNT_MAX); // R6
		if (sector_next && !sector_reg && !index_reg) begin
			sec_cnt_next = sec_cnt_reg + SEC_W'(1); // R10 R11 R14
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bit_cnt_reg <= PRESET_DEF;
			sec_cnt_reg <= '0;
			sector_reg  <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			sec_cnt_reg <= sec_cnt_next;
			sector_reg  <= sector_next;
		end
	end

	// Outputs come straight from flip-flops
	assign index_out      = index_reg; // R5
	assign sector_out     = sector_reg; // R10
	assign present_sector = sec_cnt_reg; // R11

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Length of the running index pulse; the sequence form of the width check
	// only samples the start and the end of the pulse.
	logic [IDX_W-1:0] idx_run_reg;
	logic [IDX_W-1:0] idx_run_next;

	always_comb begin
		idx_run_next = index_reg ? idx_run_reg + IDX_W'(1) : '0;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idx_run_reg <= '0;
		end else begin
			idx_run_reg <= idx_run_next;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_timer_retrig: assert property ( // R2
		dibit_rise |=> tmr_active [*8]
	) else $error("missing dibit timer not restarted by dibit");

	a_timer_expire: assert property ( // R2
		(tmr_reg == TMR_W'(1)) && !dibit_rise |=> !tmr_active
	) else $error("missing dibit timer did not expire");

	a_shift_load: assert property ( // R3
		tick403 |=> shift_reg[0] == $past(tmr_active)
			&& shift_reg[IDX_SR_W-1:1] == $past(shift_reg[IDX_SR_W-2:0])
	) else $error("index shift register did not shift timer state");

	a_shift_hold: assert property ( // R3
		!tick403 |=> $stable(shift_reg)
	) else $error("index shift register moved without reference tick");

	a_half_clock: assert property ( // R13
		tick806 |=> half_reg != $past(half_reg)
	) else $error("403 kHz divider did not toggle");

	a_index_match: assert property ( // R4
		(idx_state_reg == ISD_IDX_WAIT) && idx_match |=> index_out
	) else $error("index not asserted on pattern match");

	a_index_width: assert property ( // R1
		$rose(index_out) |-> index_out [*8] ##42 index_out ##1 !index_out
	) else $error("index pulse width is not 2.5 us");

	a_index_reset: assert property ( // R5
		index_out |=> present_sector == '0 && bit_cnt_reg == $past(sector_preset)
	) else $error("index did not reset sector counters");

	a_sector_level: assert property ( // R6
		##1 sector_out == (bit_cnt_reg == CNT_MAX)
	) else $error("sector pulse not tied to maximum count");

	a_sector_count: assert property ( // R7 R12
		tick806 && !index_out && bit_cnt_reg != CNT_MAX
			|=> bit_cnt_reg == $past(bit_cnt_reg) + CNT_W'(1)
	) else $error("sector bit counter did not advance");

	a_sector_reload: assert property ( // R8 R9
		tick806 && !index_out && bit_cnt_reg == CNT_MAX
			|=> bit_cnt_reg == $past(sector_preset) ##1 !sector_out
	) else $error("sector bit counter did not reload preset");

	a_count_hold: assert property ( // R12
		!tick806 && !index_out |=> $stable(bit_cnt_reg)
	) else $error("sector bit counter moved without a tick");

	a_present_incr: assert property ( // R10 R11
		$rose(sector_out) && !$past(index_out)
			|-> present_sector == $past(present_sector) + SEC_W'(1)
	) else $error("present sector did not follow sector pulse");

	// One lost dibit leaves about 50 cycles between dibits; the timer must bridge it
	a_timer_one_gap: assert property ( // R2
		dibit_rise |-> ##50 tmr_active
	) else $error("missing dibit timer lapsed on a single missing dibit");

	a_index_no_long: assert property ( // R1
		index_out |-> idx_run_reg < IDX_PULSE_LOAD
	) else $error("index pulse longer than 2.5 us");

	a_index_full: assert property ( // R1
		$fell(index_out) |-> idx_run_reg == IDX_PULSE_LOAD
	) else $error("index pulse ended before 2.5 us");

	a_sector_gated: assert property ( // R5 R12
		index_out && sector_preset != CNT_MAX |=> !sector_out
	) else $error("sector pulse during index");

	a_present_hold: assert property ( // R11
		!index_out |=> $rose(sector_out) || $stable(present_sector)
	) else $error("present sector moved without a sector pulse");

endmodule
`default_nettype wire
